// *** nip_map.vh ***
`ifndef NIP_MAP_VH
`define NIP_MAP_VH
// ----------------------------------------------------------------
// register byte offsets on apb
// ----------------------------------------------------------------
`define NIP_OFS_VPRIO0 8'h00
`define NIP_OFS_VPRIO1 8'h04
`define NIP_OFS_VPRIO2 8'h08
`define NIP_OFS_VPRIO3 8'h0c
`define NIP_OFS_SENSE 8'h10
// ----------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------
`define NIP_VPRIO_RST 8'hff
`define NIP_VPRIO3_RO 8'hf0
`define NIP_VPRIO3_RST 4'hf
`define NIP_SENSE_RST 8'h00
`define NIP_SENSE_WMASK 8'hfc
// ----------------------------------------------------------------
// sensitivity register fields
// ----------------------------------------------------------------
`define NIP_PB_SEL_HI 7
`define NIP_PB_SEL_LO 6
`define NIP_PB_POL 5
`define NIP_PAF_SEL_HI 4
`define NIP_PAF_SEL_LO 3
`define NIP_PA_POL 2
// ----------------------------------------------------------------
// two-bit priority patterns
// ----------------------------------------------------------------
`define NIP_PRIO_L0 2'h2
`define NIP_PRIO_L1 2'h1
`define NIP_PRIO_L2 2'h0
`define NIP_PRIO_L3 2'h3
// ----------------------------------------------------------------
// sense selector codes
// ----------------------------------------------------------------
`define NIP_SEL_FALL_LOW 2'h0
`define NIP_SEL_RISE 2'h1
`define NIP_SEL_FALL 2'h2
`define NIP_SEL_BOTH 2'h3
// ----------------------------------------------------------------
// vector map
// ----------------------------------------------------------------
`define NIP_VEC_RESET 16'hfffe
`define NIP_VEC_TRAP 16'hfffc
`define NIP_VEC_BASE 16'hfffa
`define NIP_NVEC 14
`define NIP_VEC_TIMEBASE 1
`define NIP_VEC_EXT_FIRST 2
`define NIP_VEC_UNUSED_A 0
`define NIP_VEC_UNUSED_B 6
`define NIP_VEC_SERIAL 7
// vectors able to end full halt: port groups 0..3 (vectors 2..5) and serial peripheral
`define NIP_HALT_WAKE 14'h00bc
// vectors able to end active halt, flash and rom parts
`define NIP_AHALT_WAKE_FLASH 14'h0002
`define NIP_AHALT_WAKE_ROM 14'h00be
`endif

// *** nip_sense.v ***
`default_nettype none
module nip_sense #(
    parameter POL_OK = 1'b1
) (
    input wire i_clk, // cpu clock
    input wire i_rst_b, // sync reset, active low
    input wire i_pin, // synchronised group level
    input wire [1:0] i_sel, // sense selector
    input wire i_inv, // polarity inversion
    input wire i_clr, // drop latched edge
    output wire o_pend // request pending
);
`include "nip_map.vh"
    reg prev_r;
    reg latch_r;
    reg ev;
    reg lvl;
    wire inv = i_inv & POL_OK;
    wire rise = i_pin & ~prev_r;
    wire fall = ~i_pin & prev_r;

    always @*
    begin
        ev = 1'b0;
        lvl = 1'b0;
        case (i_sel)
            `NIP_SEL_FALL_LOW:
            begin
                ev = inv ? rise : fall;
                lvl = inv ? i_pin : ~i_pin;
            end
            `NIP_SEL_RISE: ev = inv ? fall : rise;
            `NIP_SEL_FALL: ev = inv ? rise : fall;
            `NIP_SEL_BOTH: ev = rise | fall;
            default: ev = 1'b0;
        endcase
    end

    // prev resets high: lines idle high, so no false falling edge out of reset
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            prev_r <= 1'b1;
            latch_r <= 1'b0;
        end
        else
        begin
            prev_r <= i_pin;
            if (ev)
                latch_r <= 1'b1;
            else if (i_clr)
                latch_r <= 1'b0;
        end
    end

    assign o_pend = latch_r | lvl;
endmodule // nip_sense
`default_nettype wire

// *** nip_ctrl.v ***
// Behaviour
// - four 8-bit vector priority registers, reset ff, two bits per vector
// - fourth register upper nibble reads one; only vectors 12 and 13 writable
// - stored fields use the same encoding as current priority bits
// - pattern 10 level 0, 01 level 1, 00 level 2, 11 level 3
// - writing level 0 pattern into a field leaves that field unchanged
// - reset and trap set both current priority bits
// - raised priority of running pending vector re-enters it
// - enable loads 10, disable loads 11, trap loads 11
// - branch-if-masked taken on 11, complement taken otherwise
// - halt, pop cc, enable, disable, wait change priority until next return
// - vector n at fffa minus 2n; reset fffe, trap fffc
// - hardware priority falls with vector index; 0 and 6 unused
// - port groups and serial peripheral wake from full halt
// - flash: only timebase wakes active halt; rom adds ports and serial
// - sensitivity writable only while current priority is 11
// - level 3 field clears that port group's pending request
// - sensitivity resets zero with the documented field layout
// - port b low selector codes, polarity swaps edges
// - port b high uses the selector without inversion
// - low level sense for all; high level only for port a and b low
// - highest software priority wins, ties by hardware order
// - serviced only if enabled and above current priority
// - edge requests latched and cleared on handler entry
//
// Decided for this implementation: the APB slave port and the register offsets.
`default_nettype none
`include "nip_map.vh"
module nip_ctrl #(
    parameter ADDR_W = 8,
    parameter ROM_PART = 1'b0
) (
    input wire i_clk, // cpu clock, 20 mhz
    input wire i_rst_b, // sync reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [ADDR_W-1:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    input wire i_instr_rim, // enable instruction executed
    input wire i_instr_sim, // disable instruction executed
    input wire i_instr_halt, // halt instruction executed
    input wire i_instr_wfi, // wait instruction executed
    input wire i_instr_trap, // software trap taken
    input wire i_instr_handler_return_instr, // handler return, restores priority
    input wire i_instr_popcc, // pop condition code
    input wire [1:0] i_pop_prio, // priority bits popped from stack
    input wire i_svc_ack, // cpu enters offered handler
    input wire [`NIP_NVEC-1:0] i_periph_req, // enabled peripheral requests
    input wire [3:0] i_ext_line, // port group lines, asynchronous
    output reg [1:0] o_cur_prio, // current priority bits {hi,lo}
    output reg o_irq_req, // maskable request offered
    output reg [3:0] o_irq_vec, // offered vector index
    output reg [15:0] o_vec_addr, // vector fetch address
    output reg o_branch_masked, // masked branch would be taken
    output reg o_branch_unmasked, // unmasked branch would be taken
    output reg o_wake_halt, // pending source may end full halt
    output reg o_wake_ahalt // pending source may end active halt
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [1:0] prio_level;
        input [1:0] p;
        begin
            case (p)
                `NIP_PRIO_L0: prio_level = 2'd0;
                `NIP_PRIO_L1: prio_level = 2'd1;
                `NIP_PRIO_L2: prio_level = 2'd2;
                default: prio_level = 2'd3;
            endcase
        end
    endfunction

    function [7:0] prio_merge;
        input [7:0] old_v;
        input [7:0] new_v;
        integer k;
        begin
            prio_merge = old_v;
            for (k = 0; k < 4; k = k + 1)
                if (new_v[2*k +: 2] != `NIP_PRIO_L0)
                    prio_merge[2*k +: 2] = new_v[2*k +: 2];
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] vprio0_r;
    reg [7:0] vprio1_r;
    reg [7:0] vprio2_r;
    reg [3:0] vprio3_r;
    reg [7:0] sense_r;
    reg [1:0] cur_nxt;
    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    reg [3:0] run_vec_r;
    wire [27:0] vprio_all = {vprio3_r, vprio2_r, vprio1_r, vprio0_r};
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;
    wire masked = (o_cur_prio == `NIP_PRIO_L3);
    wire [7:0] vprio3_wr = prio_merge({4'h0, vprio3_r}, {4'h0, pwdata[3:0]});

    // ----------------------------------------------------------------
    // apb slave: zero wait, ready raised in the first access cycle
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (setup)
            begin
                case (paddr)
                    `NIP_OFS_VPRIO0: prdata <= {24'h00_0000, vprio0_r};
                    `NIP_OFS_VPRIO1: prdata <= {24'h00_0000, vprio1_r};
                    `NIP_OFS_VPRIO2: prdata <= {24'h00_0000, vprio2_r};
                    `NIP_OFS_VPRIO3: prdata <= {24'h00_0000, `NIP_VPRIO3_RO | {4'h0, vprio3_r}};
                    `NIP_OFS_SENSE: prdata <= {24'h00_0000, sense_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            vprio0_r <= `NIP_VPRIO_RST;
            vprio1_r <= `NIP_VPRIO_RST;
            vprio2_r <= `NIP_VPRIO_RST;
            vprio3_r <= `NIP_VPRIO3_RST;
            sense_r <= `NIP_SENSE_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                `NIP_OFS_VPRIO0: vprio0_r <= prio_merge(vprio0_r, pwdata[7:0]);
                `NIP_OFS_VPRIO1: vprio1_r <= prio_merge(vprio1_r, pwdata[7:0]);
                `NIP_OFS_VPRIO2: vprio2_r <= prio_merge(vprio2_r, pwdata[7:0]);
                `NIP_OFS_VPRIO3: vprio3_r <= vprio3_wr[3:0];
                `NIP_OFS_SENSE:
                begin
                    if (masked)
                        sense_r <= pwdata[7:0] & `NIP_SENSE_WMASK;
                end
                default: sense_r <= sense_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // port lines: two-stage synchroniser, then sense logic
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
        end
        else
        begin
            sync1_r <= i_ext_line;
            sync2_r <= sync1_r;
        end
    end

    wire [3:0] ext_pend;
    wire [3:0] ext_clr;
    wire [1:0] sel_paf = sense_r[`NIP_PAF_SEL_HI:`NIP_PAF_SEL_LO];
    wire [1:0] sel_pb = sense_r[`NIP_PB_SEL_HI:`NIP_PB_SEL_LO];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_ext
            // port group g sits on vector g+2
            assign ext_clr[g] = (vprio_all[2*(g+`NIP_VEC_EXT_FIRST) +: 2] == `NIP_PRIO_L3)
                | (i_svc_ack & o_irq_req & (o_irq_vec == g + `NIP_VEC_EXT_FIRST));
            nip_sense #(
                .POL_OK(g == 0 || g == 2)
            ) u_sense (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_pin(sync2_r[g]),
                .i_sel(g < 2 ? sel_paf : sel_pb),
                .i_inv(g < 2 ? sense_r[`NIP_PA_POL] : sense_r[`NIP_PB_POL]),
                .i_clr(ext_clr[g]),
                .o_pend(ext_pend[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // pending vector selection
    // ----------------------------------------------------------------
    reg [`NIP_NVEC-1:0] pend;
    reg [`NIP_NVEC-1:0] eligible;
    reg [3:0] best_vec;
    reg [1:0] best_lvl;
    reg best_ok;
    reg [1:0] lvl_i;
    integer i;

    always @*
    begin
        pend = i_periph_req;
        pend[`NIP_VEC_EXT_FIRST +: 4] = ext_pend;
        pend[`NIP_VEC_UNUSED_A] = 1'b0;
        pend[`NIP_VEC_UNUSED_B] = 1'b0;
        eligible = {`NIP_NVEC{1'b0}};
        best_vec = 4'h0;
        best_lvl = 2'd0;
        best_ok = 1'b0;
        lvl_i = 2'd0;
        // walk from lowest hardware priority upward so later (lower index) wins ties
        for (i = `NIP_NVEC - 1; i >= 0; i = i - 1)
        begin
            lvl_i = prio_level(vprio_all[2*i +: 2]);
            eligible[i] = pend[i] && (lvl_i != 2'd3) && (lvl_i > prio_level(o_cur_prio));
            if (eligible[i] && (!best_ok || lvl_i >= best_lvl))
            begin
                best_ok = 1'b1;
                best_lvl = lvl_i;
                best_vec = i[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // current priority bits
    // ----------------------------------------------------------------
    always @*
    begin
        cur_nxt = o_cur_prio;
        if (i_instr_trap)
            cur_nxt = `NIP_PRIO_L3;
        else if (i_svc_ack && o_irq_req)
            cur_nxt = vprio_all[2*o_irq_vec +: 2];
        else if (i_instr_handler_return_instr || i_instr_popcc)
            cur_nxt = i_pop_prio;
        else if (i_instr_sim)
            cur_nxt = `NIP_PRIO_L3;
        else if (i_instr_rim || i_instr_halt || i_instr_wfi)
            cur_nxt = `NIP_PRIO_L0;
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_cur_prio <= `NIP_PRIO_L3;
            o_branch_masked <= 1'b1;
            o_branch_unmasked <= 1'b0;
            o_vec_addr <= `NIP_VEC_RESET;
            run_vec_r <= 4'h0;
        end
        else
        begin
            o_cur_prio <= cur_nxt;
            o_branch_masked <= (cur_nxt == `NIP_PRIO_L3);
            o_branch_unmasked <= (cur_nxt != `NIP_PRIO_L3);
            if (i_instr_trap)
                o_vec_addr <= `NIP_VEC_TRAP;
            else if (i_svc_ack && o_irq_req)
            begin
                o_vec_addr <= `NIP_VEC_BASE - {11'h000, o_irq_vec, 1'b0};
                run_vec_r <= o_irq_vec;
            end
        end
    end

    // ----------------------------------------------------------------
    // offered request and halt wake-up
    // ----------------------------------------------------------------
    // the offer is dropped for one cycle after an ack so the cpu never
    // takes a stale vector while the priority bits settle
    wire [`NIP_NVEC-1:0] ahalt_mask = ROM_PART ? `NIP_AHALT_WAKE_ROM : `NIP_AHALT_WAKE_FLASH;

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_irq_req <= 1'b0;
            o_irq_vec <= 4'h0;
            o_wake_halt <= 1'b0;
            o_wake_ahalt <= 1'b0;
        end
        else
        begin
            o_irq_req <= best_ok & ~(i_svc_ack & o_irq_req) & ~i_instr_trap;
            o_irq_vec <= best_vec;
            o_wake_halt <= |(eligible & `NIP_HALT_WAKE);
            o_wake_ahalt <= |(eligible & ahalt_mask);
        end
    end
endmodule // nip_ctrl
`default_nettype wire

// *** nip_ctrl_assertions.sv ***
`default_nettype none
module nip_ctrl_chk #(
    parameter ADDR_W = 8
) (
    input wire logic i_clk, // cpu clock
    input wire logic i_rst_b, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic i_instr_rim, // enable instruction
    input wire logic i_instr_sim, // disable instruction
    input wire logic i_instr_trap, // software trap
    input wire logic i_instr_handler_return_instr, // handler return
    input wire logic i_instr_popcc, // pop condition code
    input wire logic i_svc_ack, // handler entry
    input wire logic [1:0] o_cur_prio, // current priority
    input wire logic o_irq_req, // request offered
    input wire logic [3:0] o_irq_vec, // offered vector
    input wire logic [15:0] o_vec_addr, // vector fetch address
    input wire logic o_branch_masked, // masked branch taken
    input wire logic o_branch_unmasked // unmasked branch taken
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------------------------------
    // apb slave and cpu side relations
    // ----------------------------------------------------------------
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_apb_ready_only: assert property (pready |-> psel && penable && prdata[31:8] == 24'h0)
        else $error("ready outside access or upper data set");
    a_apb_err_map: assert property (pready |-> pslverr == (paddr > 'h10 || paddr[1:0] != 2'h0))
        else $error("error flag does not match map");
    a_rim_level0: assert property (i_instr_rim && !i_instr_sim && !i_instr_trap && !i_instr_handler_return_instr
        && !i_instr_popcc && !(i_svc_ack && o_irq_req) |=> o_cur_prio == 2'h2)
        else $error("enable did not load level 0");
    a_sim_level3: assert property (i_instr_sim && !i_instr_trap && !i_instr_handler_return_instr && !i_instr_popcc
        && !(i_svc_ack && o_irq_req) |=> o_cur_prio == 2'h3)
        else $error("disable did not load level 3");
    a_trap_vector: assert property (i_instr_trap |=> o_cur_prio == 2'h3 && o_vec_addr == 16'hfffc)
        else $error("trap vector or priority wrong");
    a_branch_pair: assert property (o_branch_masked == (o_cur_prio == 2'h3) && o_branch_unmasked != o_branch_masked)
        else $error("branch conditions wrong");
    a_ack_vector: assert property (i_svc_ack && o_irq_req && !i_instr_trap
        |=> !o_irq_req && o_vec_addr == 16'hfffa - {11'h0, $past(o_irq_vec), 1'b0})
        else $error("vector address after entry wrong");
    a_vec_valid: assert property (o_irq_req |-> o_irq_vec != 4'h0 && o_irq_vec != 4'h6 && o_irq_vec <= 4'hd)
        else $error("unused vector offered");
endmodule // nip_ctrl_chk
`default_nettype wire

// *** nip_cpu_model.sv ***
`default_nettype none
module nip_cpu_model (
    input wire logic i_clk, // cpu clock
    input wire logic i_rst_b, // sync reset, active low
    input wire logic i_req, // request offered
    input wire logic i_en, // cpu takes interrupts
    input wire logic [3:0] i_wait, // cycles before entry
    output logic o_ack // handler entry pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // one-cycle entry only while offered; re-arm after, since request drops
    always @(posedge i_clk)
    begin
        if (!i_rst_b || !i_en || !i_req || o_ack)
        begin
            cnt_r <= 4'h0;
            o_ack <= 1'b0;
        end
        else if (cnt_r == i_wait)
            o_ack <= 1'b1;
        else
            cnt_r <= cnt_r + 4'h1;
    end
endmodule // nip_cpu_model
`default_nettype wire

// *** nip_ctrl_tb.sv ***
`default_nettype none
module nip_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_b, psel, penable, pwrite, pready, pslverr, ack, ack_en;
    logic o_irq_req, o_branch_masked, o_branch_unmasked, o_wake_halt, o_wake_ahalt, err;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic [6:0] ins;
    logic [1:0] pop, o_cur_prio;
    logic [13:0] preq;
    logic [3:0] ext, o_irq_vec;
    logic [15:0] o_vec_addr;
    int fail_count, num_checks;
    nip_ctrl #(.ADDR_W(8), .ROM_PART(1'b0)) u_nip_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_instr_rim(ins[0]), .i_instr_sim(ins[1]), .i_instr_halt(ins[2]),
        .i_instr_wfi(ins[3]), .i_instr_trap(ins[4]), .i_instr_handler_return_instr(ins[5]), .i_instr_popcc(ins[6]),
        .i_pop_prio(pop), .i_svc_ack(ack), .i_periph_req(preq), .i_ext_line(ext), .o_cur_prio(o_cur_prio),
        .o_irq_req(o_irq_req), .o_irq_vec(o_irq_vec), .o_vec_addr(o_vec_addr), .o_branch_masked(o_branch_masked),
        .o_branch_unmasked(o_branch_unmasked), .o_wake_halt(o_wake_halt), .o_wake_ahalt(o_wake_ahalt));
    nip_cpu_model u_nip_cpu_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_irq_req), .i_en(ack_en),
        .i_wait(4'h2), .o_ack(ack));
    always #25 i_clk = ~i_clk;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge i_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            check(16'h0, 16'h1);
            stop_test;
        end
        // idle edge so a following call never re-drives psel in this time step
        @(posedge i_clk);
    endtask
    task automatic pulse(input int k, input logic [1:0] pp);
        pop <= pp;
        ins <= 7'h1 << k;
        @(posedge i_clk);
        ins <= 7'h0;
        @(posedge i_clk);
    endtask
    // waits on an offered vector, or on a fetch address when addr is set
    task automatic wait_on(input bit addr, input logic [15:0] v);
        int n;
        n = 0;
        while ((addr ? o_vec_addr !== v : !(o_irq_req === 1'b1 && o_irq_vec === v[3:0])) && n < 30)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n == 30)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: wait ran out for %h", $time, v);
            stop_test;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check(o_cur_prio, 2'h3);
        check(o_vec_addr, 16'hfffe);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 8'h0);
            check(q, i == 4 ? 8'h00 : 8'hff);
        end
        apb(1'b0, 8'h14, 8'h0);
        check(q, 8'h00);
        check(err, 1'b1);
    endtask
    task automatic t_prio;
        apb(1'b1, 8'h00, 8'hcf);
        apb(1'b1, 8'h00, 8'h64);
        apb(1'b0, 8'h00, 8'h0);
        check(q, 8'h44);
        apb(1'b1, 8'h0c, 8'h00);
        apb(1'b0, 8'h0c, 8'h0);
        check(q, 8'hf0);
        apb(1'b1, 8'h0c, 8'hff);
        apb(1'b1, 8'h00, 8'hff);
    endtask
    task automatic t_instr;
        logic [1:0] exp [5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
        for (int k = 0; k < 5; k++)
        begin
            pulse(k, 2'h0);
            check(o_cur_prio, exp[k]);
            check(o_branch_masked, exp[k] == 2'h3);
        end
        check(o_vec_addr, 16'hfffc);
        pulse(6, 2'h1);
        check(o_cur_prio, 2'h1);
        pulse(1, 2'h0);
    endtask
    task automatic t_sense;
        apb(1'b1, 8'h10, 8'hff);
        apb(1'b0, 8'h10, 8'h0);
        check(q, 8'hfc);
        pulse(0, 2'h0);
        apb(1'b1, 8'h10, 8'h00);
        apb(1'b0, 8'h10, 8'h0);
        check(q, 8'hfc);
        pulse(1, 2'h0);
        apb(1'b1, 8'h10, 8'h10);
    endtask
    task automatic t_ext;
        apb(1'b1, 8'h00, 8'hdf);
        pulse(0, 2'h0);
        ext <= 4'he;
        wait_on(1'b0, 16'h2);
        check(o_wake_halt, 1'b1);
        check(o_wake_ahalt, 1'b0);
        apb(1'b1, 8'h00, 8'hff);
        apb(1'b1, 8'h00, 8'hdf);
        repeat (3) @(posedge i_clk);
        check(o_irq_req, 1'b0);
        ext <= 4'hf;
    endtask
    task automatic t_service;
        apb(1'b1, 8'h04, 8'h7f);
        apb(1'b1, 8'h08, 8'hf0);
        ack_en <= 1'b1;
        preq <= 14'h0080;
        wait_on(1'b1, 16'hffec);
        check(o_cur_prio, 2'h1);
        preq <= 14'h0300;
        wait_on(1'b1, 16'hffea);
        check(o_cur_prio, 2'h0);
        preq <= 14'h0200;
        repeat (4) @(posedge i_clk);
        check(o_irq_req, 1'b0);
        pulse(5, 2'h1);
        wait_on(1'b1, 16'hffe8);
        preq <= 14'h0;
        ack_en <= 1'b0;
        pulse(1, 2'h0);
    endtask
    initial
    begin
        i_clk = 1'b0;
        i_rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        ins = 7'h0;
        pop = 2'h0;
        preq = 14'h0;
        ext = 4'hf;
        ack_en = 1'b0;
        fail_count = 0;
        num_checks = 0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        @(posedge i_clk);
        t_reset;
        t_prio;
        t_instr;
        t_sense;
        t_ext;
        t_service;
        stop_test;
    end
endmodule // nip_ctrl_tb
bind nip_ctrl nip_ctrl_chk #(.ADDR_W(ADDR_W)) u_nip_ctrl_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_instr_rim(i_instr_rim), .i_instr_sim(i_instr_sim), .i_instr_trap(i_instr_trap),
    .i_instr_handler_return_instr(i_instr_handler_return_instr), .i_instr_popcc(i_instr_popcc), .i_svc_ack(i_svc_ack), .o_cur_prio(o_cur_prio),
    .o_irq_req(o_irq_req), .o_irq_vec(o_irq_vec), .o_vec_addr(o_vec_addr), .o_branch_masked(o_branch_masked),
    .o_branch_unmasked(o_branch_unmasked));
`default_nettype wire
